// [lcd_drv_pkg.sv]
package lcd_drv_pkg;
    localparam int SEGS = 40;
    localparam int ROWS = 4;
    localparam int COL_W = 6;
    localparam int ROW_W = 2;
    // Drive mode field values.
    localparam logic [1:0] DRV_QUAD = 2'h0;
    localparam logic [1:0] DRV_STATIC = 2'h1;
    localparam logic [1:0] DRV_DUP = 2'h2;
    localparam logic [1:0] DRV_TRI = 2'h3;
    // Output voltage level codes along the bias divider.
    localparam logic [1:0] LVL_VSS = 2'h0;
    localparam logic [1:0] LVL_LOW = 2'h1;
    localparam logic [1:0] LVL_HIGH = 2'h2;
    localparam logic [1:0] LVL_VLCD = 2'h3;
    // Last scanned row per drive mode.
    localparam logic [1:0] LAST_ROW_STATIC = 2'h0;
    localparam logic [1:0] LAST_ROW_DUP = 2'h1;
    localparam logic [1:0] LAST_ROW_TRI = 2'h2;
    localparam logic [1:0] LAST_ROW_QUAD = 2'h3;
    localparam logic [1:0] BANK_ROW_OFS = 2'h2;
    // Blink rate field values.
    localparam logic [1:0] BLINK_OFF = 2'h0;
    localparam logic [1:0] BLINK_RATE1 = 2'h1;
    localparam logic [1:0] BLINK_RATE2 = 2'h2;
    // Reset values of the configuration.
    localparam logic [1:0] RST_DRIVE = DRV_QUAD;
    localparam logic [1:0] RST_ROW = 2'h0;
    // Row period of the internal oscillator and frames per blink step.
    localparam int CLK_PERIOD_NS = 10;
    localparam int ROW_TIME_NS = 2000000;
    localparam int ROW_CYCLES = ROW_TIME_NS / CLK_PERIOD_NS;
    localparam int BLINK_BASE_FRAMES = 16;
endpackage

// [tick_divider.sv]
`timescale 1ns/10ps
module tick_divider #(
    parameter int unsigned DIV = 4
) (
    input wire logic clk, // System clock.
    input wire logic rst_b, // Asynchronous reset, active low.
    input wire logic en, // Count enable.
    output logic tick // One pulse every DIV enables.
);
    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] CNT_LAST = CW'(DIV - 1);
    logic [CW-1:0] cnt_r;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r <= '0;
            tick <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (en) begin
                if (cnt_r >= CNT_LAST) begin
                    cnt_r <= '0;
                    tick <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + CW'(1);
                end
            end
        end
    end
endmodule

// [lcd_drive.sv]
`timescale 1ns/10ps
module lcd_drive #(
    parameter int unsigned ROW_DIV = lcd_drv_pkg::ROW_CYCLES
) (
    input wire logic clk, // System clock, 100 MHz.
    input wire logic rst_b, // Asynchronous reset, active low.
    input wire logic oscillator_source_pin, // Low selects internal oscillator.
    input wire logic ext_osc_tick, // External row clock enable, one cycle.
    input wire logic mode_set_valid, // Mode-set command strobe.
    input wire logic mode_set_enable, // Display enable bit.
    input wire logic mode_set_bias_half, // One selects half bias.
    input wire logic [1:0] mode_set_drive, // Drive mode field.
    input wire logic bank_set_valid, // Bank-select command strobe.
    input wire logic bank_set_input, // Input bank bit.
    input wire logic bank_set_output, // Output bank bit.
    input wire logic blink_set_valid, // Blink-select command strobe.
    input wire logic alternate_blink_bit, // Blink by bank swap.
    input wire logic [1:0] blink_rate_field, // Blink rate.
    input wire logic ram_wr_valid, // Display RAM bit write strobe.
    input wire logic [5:0] ram_wr_col, // RAM column, 0 to 39.
    input wire logic [1:0] ram_wr_row, // RAM row within bank.
    input wire logic ram_wr_bit, // Bit to store.
    output logic [1:0] backplane_out_0, // Backplane 0 level code.
    output logic [1:0] backplane_out_1, // Backplane 1 level code.
    output logic [1:0] backplane_out_2, // Backplane 2 level code.
    output logic [1:0] backplane_out_3, // Backplane 3 level code.
    output logic [2*lcd_drv_pkg::SEGS-1:0] segment_out, // Two bits per segment.
    output logic bias_bypass, // Centre divider element bypass switch.
    output logic display_active // Display enabled and showing.
);
    logic en_r;
    logic bias_half_r;
    logic [1:0] drive_r;
    logic bank_in_r;
    logic bank_out_r;
    logic ab_r;
    logic [1:0] bf_r;
    logic [3:0] ram [lcd_drv_pkg::SEGS];
    logic [1:0] row_r;
    logic [1:0] row_nxt;
    logic [1:0] last_row;
    logic phase_r;
    logic frame_end;
    logic row_tick;
    logic blink_tick;
    logic [2:0] blink_cnt_r;
    logic blink_on;
    logic [1:0] ram_row;
    logic [lcd_drv_pkg::SEGS-1:0] disp_r;
    logic is_static;
    logic paired;
    logic blank;
    logic [1:0] bp_lvl [4];

    ////////////////////////////////////////////////////////////////////////////
    // command strobes load configuration
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            en_r <= 1'b0;
            bias_half_r <= 1'b0;
            drive_r <= lcd_drv_pkg::RST_DRIVE;
        end else if (mode_set_valid) begin
            en_r <= mode_set_enable;
            bias_half_r <= mode_set_bias_half;
            drive_r <= mode_set_drive;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bank_in_r <= 1'b0;
            bank_out_r <= 1'b0;
        end else if (bank_set_valid) begin
            bank_in_r <= bank_set_input;
            bank_out_r <= bank_set_output;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ab_r <= 1'b0;
            bf_r <= lcd_drv_pkg::BLINK_OFF;
        end else if (blink_set_valid) begin
            ab_r <= alternate_blink_bit;
            bf_r <= blink_rate_field;
        end
    end

    assign is_static = (drive_r == lcd_drv_pkg::DRV_STATIC);
    // Banks exist only where a mode leaves rows spare.
    assign paired = is_static || (drive_r == lcd_drv_pkg::DRV_DUP);

    ////////////////////////////////////////////////////////////////////////////
    // Display RAM, written one bit at a time; in static and 1:2 modes the input bank moves the row.
    always_ff @(posedge clk) begin
        if (ram_wr_valid && (ram_wr_col < 6'(lcd_drv_pkg::SEGS))) begin
            ram[ram_wr_col][ram_wr_row + ((bank_in_r && paired) ? lcd_drv_pkg::BANK_ROW_OFS : 2'h0)]
                <= ram_wr_bit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // internal oscillator select
    tick_divider #(
        .DIV(ROW_DIV)
    ) u_row_div (
        .clk(clk),
        .rst_b(rst_b),
        .en(oscillator_source_pin ? ext_osc_tick : 1'b1),
        .tick(row_tick)
    );

    tick_divider #(
        .DIV(lcd_drv_pkg::BLINK_BASE_FRAMES)
    ) u_blink_div (
        .clk(clk),
        .rst_b(rst_b),
        .en(frame_end),
        .tick(blink_tick)
    );

    // last row follows latest drive mode
    always_comb begin
        case (drive_r)
            lcd_drv_pkg::DRV_STATIC: last_row = lcd_drv_pkg::LAST_ROW_STATIC;
            lcd_drv_pkg::DRV_DUP: last_row = lcd_drv_pkg::LAST_ROW_DUP;
            lcd_drv_pkg::DRV_TRI: last_row = lcd_drv_pkg::LAST_ROW_TRI;
            default: last_row = lcd_drv_pkg::LAST_ROW_QUAD;
        endcase
    end

    // row scan wraps at the mode's last row
    assign frame_end = row_tick && (row_r >= last_row);
    assign row_nxt = frame_end ? lcd_drv_pkg::RST_ROW : row_r + 2'h1;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            row_r <= lcd_drv_pkg::RST_ROW;
            phase_r <= 1'b0;
        end else if (row_tick) begin
            row_r <= row_nxt;
            phase_r <= phase_r ^ frame_end;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            blink_cnt_r <= 3'h0;
        end else if (blink_tick) begin
            blink_cnt_r <= blink_cnt_r + 3'h1;
        end
    end

    always_comb begin
        case (bf_r)
            lcd_drv_pkg::BLINK_OFF: blink_on = 1'b0;
            lcd_drv_pkg::BLINK_RATE1: blink_on = blink_cnt_r[0];
            lcd_drv_pkg::BLINK_RATE2: blink_on = blink_cnt_r[1];
            default: blink_on = blink_cnt_r[2];
        endcase
    end

    // Alternate blink swaps banks where banks exist, else blanks.
    assign ram_row = row_nxt + (((bank_out_r ^ (blink_on && ab_r)) && paired) ? lcd_drv_pkg::BANK_ROW_OFS : 2'h0);

    ////////////////////////////////////////////////////////////////////////////
    // display register loads once per row
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            disp_r <= '0;
        end else if (row_tick) begin
            for (int i = 0; i < lcd_drv_pkg::SEGS; i++) begin
                disp_r[i] <= ram[i][ram_row];
            end
        end
    end

    // blank while disabled or in the off blink phase, unless alternate blink swaps banks
    assign blank = !en_r || (blink_on && !(ab_r && paired));

    // physical backplane to scanned row mapping
    always_comb begin
        for (int k = 0; k < lcd_drv_pkg::ROWS; k++) begin
            logic sel;
            sel = 1'b0;
            case (drive_r)
                // all backplanes share the static signal
                lcd_drv_pkg::DRV_STATIC: sel = 1'b1;
                // even and odd backplanes pair up
                lcd_drv_pkg::DRV_DUP: sel = (2'(k % 2) == row_r);
                lcd_drv_pkg::DRV_TRI: sel = ((k == 3) ? 2'h1 : 2'(k)) == row_r;
                default: sel = (2'(k) == row_r);
            endcase
            if (sel) begin
                bp_lvl[k] = phase_r ? lcd_drv_pkg::LVL_VSS : lcd_drv_pkg::LVL_VLCD;
            end else if (bias_half_r || !phase_r) begin
                // half bias uses the centre level for unselected rows
                bp_lvl[k] = lcd_drv_pkg::LVL_LOW;
            end else begin
                bp_lvl[k] = lcd_drv_pkg::LVL_HIGH;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            backplane_out_0 <= lcd_drv_pkg::LVL_VSS;
            backplane_out_1 <= lcd_drv_pkg::LVL_VSS;
            backplane_out_2 <= lcd_drv_pkg::LVL_VSS;
            backplane_out_3 <= lcd_drv_pkg::LVL_VSS;
        end else begin
            backplane_out_0 <= blank ? lcd_drv_pkg::LVL_VSS : bp_lvl[0];
            backplane_out_1 <= blank ? lcd_drv_pkg::LVL_VSS : bp_lvl[1];
            backplane_out_2 <= blank ? lcd_drv_pkg::LVL_VSS : bp_lvl[2];
            backplane_out_3 <= blank ? lcd_drv_pkg::LVL_VSS : bp_lvl[3];
        end
    end

    // segment level from display bit and row phase
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            segment_out <= '0;
        end else begin
            for (int i = 0; i < lcd_drv_pkg::SEGS; i++) begin
                if (blank) begin
                    segment_out[2*i +: 2] <= lcd_drv_pkg::LVL_VSS;
                end else if (disp_r[i]) begin
                    segment_out[2*i +: 2] <= phase_r ? lcd_drv_pkg::LVL_VLCD : lcd_drv_pkg::LVL_VSS;
                end else if (is_static) begin
                    segment_out[2*i +: 2] <= phase_r ? lcd_drv_pkg::LVL_VSS : lcd_drv_pkg::LVL_VLCD;
                end else if (bias_half_r || phase_r) begin
                    segment_out[2*i +: 2] <= lcd_drv_pkg::LVL_LOW;
                end else begin
                    segment_out[2*i +: 2] <= lcd_drv_pkg::LVL_HIGH;
                end
            end
        end
    end

    // bias bypass switch follows half bias
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bias_bypass <= 1'b0;
            display_active <= 1'b0;
        end else begin
            bias_bypass <= bias_half_r;
            display_active <= !blank;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_tri_bp_mirror: assert property ((drive_r == lcd_drv_pkg::DRV_TRI) && $stable(drive_r) |=>
        backplane_out_3 == backplane_out_1) else $error("bp3 differs from bp1 in 1:3 mode");
    a_dup_bp_pairs: assert property ((drive_r == lcd_drv_pkg::DRV_DUP) && $stable(drive_r) |=>
        (backplane_out_0 == backplane_out_2) && (backplane_out_1 == backplane_out_3))
        else $error("backplane pairs differ in 1:2 mode");
    a_static_bp_same: assert property (is_static && $stable(drive_r) |=>
        (backplane_out_0 == backplane_out_1) && (backplane_out_2 == backplane_out_3)
        && (backplane_out_0 == backplane_out_2)) else $error("static backplanes differ");
    a_blank_when_off: assert property (!en_r ##1 !en_r |->
        (segment_out == '0) && (backplane_out_0 == lcd_drv_pkg::LVL_VSS)) else $error("output not blank");
    a_enable_shows: assert property (mode_set_valid && mode_set_enable && (bf_r == lcd_drv_pkg::BLINK_OFF)
        && !blink_set_valid |=> ##1 display_active) else $error("display not on after enable");
    a_bias_switch: assert property (mode_set_valid && mode_set_bias_half |=> ##1 bias_bypass)
        else $error("bypass switch not closed for half bias");
    a_row_wraps: assert property (row_tick && (row_r >= last_row) |=> row_r == lcd_drv_pkg::RST_ROW)
        else $error("row scan did not wrap");
    a_row_mode_bound: assert property (row_tick && $stable(drive_r) && (row_r < last_row) |=>
        (row_r <= $past(last_row)) && (row_r == $past(row_r) + 2'h1)) else $error("row out of mode range");
    a_disp_hold: assert property (!row_tick |=> $stable(disp_r))
        else $error("display register changed mid row");
    a_ext_osc_gate: assert property ((oscillator_source_pin && !ext_osc_tick) [*2] |-> !row_tick)
        else $error("row tick without oscillator");
    a_seg_on_full: assert property (!blank && disp_r[0] && !is_static |=>
        segment_out[1:0] == ($past(phase_r) ? lcd_drv_pkg::LVL_VLCD : lcd_drv_pkg::LVL_VSS))
        else $error("lit segment not at full level");

    c_frame_quad: cover property (frame_end && (drive_r == lcd_drv_pkg::DRV_QUAD) && en_r);
    c_frame_tri: cover property (frame_end && (drive_r == lcd_drv_pkg::DRV_TRI) && en_r);
    c_half_dup: cover property (frame_end && (drive_r == lcd_drv_pkg::DRV_DUP) && bias_half_r);
    c_blink_swap: cover property (blink_tick && ab_r && paired);
endmodule

// [host_model.sv]
`timescale 1ns/10ps
module host_model (
    input wire logic clk, // System clock.
    output logic mode_set_valid, // Mode-set strobe.
    output logic mode_set_enable, // Display enable.
    output logic mode_set_bias_half, // Half bias select.
    output logic [1:0] mode_set_drive, // Drive mode.
    output logic bank_set_valid, // Bank-select strobe.
    output logic bank_set_input, // Input bank.
    output logic bank_set_output, // Output bank.
    output logic blink_set_valid, // Blink-select strobe.
    output logic alternate_blink_bit, // Blink by bank swap.
    output logic [1:0] blink_rate_field, // Blink rate.
    output logic ram_wr_valid, // RAM write strobe.
    output logic [5:0] ram_wr_col, // RAM column.
    output logic [1:0] ram_wr_row, // RAM row.
    output logic ram_wr_bit // RAM bit.
);
    initial begin
        {mode_set_valid, bank_set_valid, blink_set_valid, ram_wr_valid} = 4'h0;
        {mode_set_enable, mode_set_bias_half, mode_set_drive, bank_set_input, bank_set_output} = 6'h15;
        {alternate_blink_bit, blink_rate_field, ram_wr_col, ram_wr_row, ram_wr_bit} = 12'hAAA;
    end
    ////////////////////////////////////////////////////////////////
    // Each command is one clock wide; released fields are inverted so stale values never look valid.
    task automatic mode(input logic [3:0] f);
        @(posedge clk);
        #1;
        {mode_set_valid, mode_set_enable, mode_set_bias_half, mode_set_drive} = {1'h1, f};
        @(posedge clk);
        #1;
        {mode_set_valid, mode_set_enable, mode_set_bias_half, mode_set_drive} = {1'h0, ~f};
    endtask
    task automatic bank(input logic [1:0] f);
        @(posedge clk);
        #1;
        {bank_set_valid, bank_set_input, bank_set_output} = {1'h1, f};
        @(posedge clk);
        #1;
        {bank_set_valid, bank_set_input, bank_set_output} = {1'h0, ~f};
    endtask
    task automatic blink(input logic [2:0] f);
        @(posedge clk);
        #1;
        {blink_set_valid, alternate_blink_bit, blink_rate_field} = {1'h1, f};
        @(posedge clk);
        #1;
        {blink_set_valid, alternate_blink_bit, blink_rate_field} = {1'h0, ~f};
    endtask
    // each write names its column, standing in for a loaded pointer and matched subaddress.
    task automatic wr(input logic [8:0] f);
        @(posedge clk);
        #1;
        {ram_wr_valid, ram_wr_col, ram_wr_row, ram_wr_bit} = {1'h1, f};
        @(posedge clk);
        #1;
        {ram_wr_valid, ram_wr_col, ram_wr_row, ram_wr_bit} = {1'h0, ~f};
    endtask
    ////////////////////////////////////////////////////////////////
    // serial wake-up precedes this; no port of the block carries it.
    task automatic setup();
        mode({1'h0, 1'h0, lcd_drv_pkg::DRV_QUAD});
        bank(2'h0);
        blink({1'h0, lcd_drv_pkg::BLINK_OFF});
    endtask
endmodule

// [tb_segment_lcd_init_and_backplane_drive.sv]
`timescale 1ns/10ps
module tb_segment_lcd_init_and_backplane_drive;
    localparam int DIV = 4;
    localparam logic [3:0] EXP0 = 4'h5;
    localparam logic [3:0] EXP39 = 4'h6;
    logic clk, rst_b, oscillator_source_pin, ext_osc_tick, mode_set_valid, mode_set_enable, mode_set_bias_half;
    logic bank_set_valid, bank_set_input, bank_set_output, blink_set_valid, alternate_blink_bit;
    logic ram_wr_valid, ram_wr_bit, bias_bypass, display_active;
    logic [1:0] mode_set_drive, blink_rate_field, ram_wr_row;
    logic [1:0] backplane_out_0, backplane_out_1, backplane_out_2, backplane_out_3;
    logic [5:0] ram_wr_col;
    logic [79:0] segment_out;
    logic [1:0] bp [4];
    int fail_count, cmp_count;
    assign bp[0] = backplane_out_0;
    assign bp[1] = backplane_out_1;
    assign bp[2] = backplane_out_2;
    assign bp[3] = backplane_out_3;
    lcd_drive #(.ROW_DIV(DIV)) dut_u (.clk, .rst_b, .oscillator_source_pin, .ext_osc_tick, .mode_set_valid,
        .mode_set_enable, .mode_set_bias_half, .mode_set_drive, .bank_set_valid, .bank_set_input, .bank_set_output,
        .blink_set_valid, .alternate_blink_bit, .blink_rate_field, .ram_wr_valid, .ram_wr_col, .ram_wr_row,
        .ram_wr_bit, .backplane_out_0, .backplane_out_1, .backplane_out_2, .backplane_out_3, .segment_out,
        .bias_bypass, .display_active);
    host_model host_u (.clk, .mode_set_valid, .mode_set_enable, .mode_set_bias_half, .mode_set_drive,
        .bank_set_valid, .bank_set_input, .bank_set_output, .blink_set_valid, .alternate_blink_bit,
        .blink_rate_field, .ram_wr_valid, .ram_wr_col, .ram_wr_row, .ram_wr_bit);
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Finds which active backplane sits at a select level and how many do.
    task automatic pick(input int last, output int idx, output int n);
        idx = 0;
        n = 0;
        for (int i = 0; i <= last; i++) begin
            if (bp[i] === 2'h0 || bp[i] === 2'h3) begin
                idx = i;
                n++;
            end
        end
    endtask
    task automatic t_blank(input int cyc);
        repeat (3) @(negedge clk);
        repeat (cyc) begin
            @(negedge clk);
            check({backplane_out_0, backplane_out_1, backplane_out_2, backplane_out_3}, 8'h00);
            check(8'(|segment_out), 8'h00);
            check(8'(display_active), 8'h00);
        end
    endtask
    task automatic t_scan(input logic [1:0] drv, input int last);
        int idx, n, prev, steps;
        logic [1:0] lv, un;
        host_u.mode({1'h1, 1'h0, drv});
        repeat (5 * DIV) @(negedge clk);
        pick(last, prev, n);
        steps = 0;
        repeat (12 * DIV) begin
            @(negedge clk);
            pick(last, idx, n);
            lv = bp[idx];
            un = (last == 0) ? lv : ((lv == 2'h3) ? 2'h2 : 2'h1);
            check(8'(n), 8'h01);
            check(8'(display_active), 8'h01);
            if (idx != prev) begin
                check(8'(idx), 8'((prev == last) ? 0 : prev + 1));
                steps++;
            end
            prev = idx;
            check(8'(segment_out[1:0]), 8'(EXP0[idx] ? 2'h3 - lv : un));
            check(8'(segment_out[79:78]), 8'(EXP39[idx] ? 2'h3 - lv : un));
            if (last == 0) check(8'({backplane_out_1, backplane_out_2, backplane_out_3}), 8'({3{backplane_out_0}}));
            if (last == 1) check(8'({backplane_out_2, backplane_out_3}), 8'({backplane_out_0, backplane_out_1}));
            if (last == 2) check(8'(backplane_out_3), 8'(backplane_out_1));
        end
        check(8'(steps >= ((last > 0) ? 3 : 0)), 8'h01);
    endtask
    task automatic t_half();
        int idx, n;
        host_u.mode({1'h1, 1'h1, lcd_drv_pkg::DRV_DUP});
        repeat (3) @(negedge clk);
        check(8'(bias_bypass), 8'h01);
        repeat (4 * DIV) begin
            @(negedge clk);
            pick(1, idx, n);
            check(8'(n), 8'h01);
            check(8'(bp[1 - idx]), 8'h01);
        end
        host_u.mode({1'h1, 1'h0, lcd_drv_pkg::DRV_DUP});
        repeat (3) @(negedge clk);
        check(8'(bias_bypass), 8'h00);
    endtask
    task automatic t_ext();
        int a, z, n;
        host_u.mode({1'h1, 1'h0, lcd_drv_pkg::DRV_QUAD});
        repeat (2 * DIV) @(posedge clk);
        #1;
        oscillator_source_pin = 1'h1;
        repeat (2 * DIV) @(negedge clk);
        pick(3, a, n);
        repeat (8 * DIV) @(negedge clk);
        pick(3, z, n);
        check(8'(z), 8'(a));
        repeat (2 * DIV) begin
            @(posedge clk);
            #1;
            ext_osc_tick = 1'h1;
            @(posedge clk);
            #1;
            ext_osc_tick = 1'h0;
        end
        repeat (4) @(negedge clk);
        pick(3, z, n);
        check(8'(z), 8'((a + 2) % 4));
        @(posedge clk);
        #1;
        oscillator_source_pin = 1'h0;
    endtask
    // Output bank 1 shows rows 2 and 3; input bank 1 moves a write into row 2.
    task automatic t_bank();
        int idx, n;
        logic [1:0] lv, un;
        host_u.mode({1'h1, 1'h0, lcd_drv_pkg::DRV_DUP});
        host_u.bank(2'h3);
        host_u.wr({6'h00, 2'h0, 1'h0});
        repeat (5 * DIV) @(negedge clk);
        repeat (4 * DIV) begin
            @(negedge clk);
            pick(1, idx, n);
            lv = bp[idx];
            un = (lv == 2'h3) ? 2'h2 : 2'h1;
            check(8'(segment_out[1:0]), 8'(un));
            check(8'(segment_out[79:78]), 8'(EXP39[idx + 2] ? 2'h3 - lv : un));
        end
        host_u.bank(2'h0);
        host_u.wr({6'h00, 2'h2, EXP0[2]});
    endtask
    // Counts blank cycles over a whole number of blink periods once the blink ticks are regular.
    task automatic t_blink(input logic [1:0] drv, input logic [2:0] bl, input int exp_off);
        int off;
        host_u.mode({1'h1, 1'h0, drv});
        host_u.blink(bl);
        repeat (300) @(negedge clk);
        off = 0;
        repeat (512) begin
            @(negedge clk);
            off += (display_active === 1'h0);
        end
        check(8'(off == exp_off), 8'h01);
        host_u.blink({1'h0, lcd_drv_pkg::BLINK_OFF});
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    initial begin
        rst_b = 1'h0;
        oscillator_source_pin = 1'h0;
        ext_osc_tick = 1'h0;
        repeat (4) @(posedge clk);
        #1;
        rst_b = 1'h1;
        host_u.setup();
        for (int r = 0; r < 4; r++) begin
            host_u.wr({6'h00, 2'(r), EXP0[r]});
            host_u.wr({6'h27, 2'(r), EXP39[r]});
        end
        for (int c = 1; c < 39; c++) begin
            for (int r = 0; r < 4; r++) begin
                host_u.wr({6'(c), 2'(r), 1'h0});
            end
        end
        t_blank(20);
        t_scan(lcd_drv_pkg::DRV_QUAD, 3);
        t_scan(lcd_drv_pkg::DRV_TRI, 2);
        t_scan(lcd_drv_pkg::DRV_DUP, 1);
        t_scan(lcd_drv_pkg::DRV_STATIC, 0);
        t_half();
        t_bank();
        t_blink(lcd_drv_pkg::DRV_QUAD, {1'h1, lcd_drv_pkg::BLINK_RATE1}, 256);
        t_blink(lcd_drv_pkg::DRV_DUP, {1'h0, lcd_drv_pkg::BLINK_RATE2}, 256);
        t_blink(lcd_drv_pkg::DRV_DUP, {1'h1, lcd_drv_pkg::BLINK_RATE1}, 0);
        t_ext();
        host_u.mode({1'h0, 1'h0, lcd_drv_pkg::DRV_QUAD});
        t_blank(20);
        print_verdict();
    end
endmodule
